// [core/nac_ctrl.sv]
// nac_ctrl: memory access controller for the data EEPROM and program flash,
// reached over APB, with the write unlock sequence and the write timer.
// assumes: rst_n_i is power-on reset; the two reset inputs are one-cycle
// pulses synchronous to clk_sys_i; the CPU honours the stall and irq hold.
`timescale 1ns/100ps
`default_nettype none

`include "nac_regs.svh"

module nac_ctrl
   import nac_pkg::*;
#(
   parameter int unsigned DATA_WR_CYCLES = `NAC_DATA_WR_CYC,
   parameter int unsigned PROG_WR_CYCLES = `NAC_PROG_WR_CYC
)
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        external_reset_pin_i,
   input  wire logic        watchdog_timeout_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             cpu_stall_o,
   output logic             irq_hold_o
);

   nac_ctl_t    st;
   nac_ctl_t    next_st;
   logic        soft_reset;
   logic        acc_wr;
   logic        setup_rd;
   logic        mapped;
   logic [7:0]  wbyte;
   logic        tmr_start;
   logic        tmr_done;
   logic [31:0] tmr_load;
   logic        ee_we;
   logic        fl_we;
   logic [7:0]  ee_rdata;
   logic [13:0] fl_rdata;
   logic [12:0] prog_addr;
   logic [13:0] prog_word;

   ////////////////////////////////////////////////////////////////////////////
   // address decode and bus qualifiers
   assign soft_reset = external_reset_pin_i | watchdog_timeout_i;
   assign acc_wr     = psel_i & penable_i & pwrite_i & pstrb_i[0];
   assign setup_rd   = psel_i & ~penable_i & ~pwrite_i;
   assign wbyte      = pwdata_i[7:0];
   assign mapped     = (paddr_i == `NAC_OFS_DATA_LOW)  || (paddr_i == `NAC_OFS_DATA_HIGH) ||
                       (paddr_i == `NAC_OFS_ADDR_LOW)  || (paddr_i == `NAC_OFS_ADDR_HIGH) ||
                       (paddr_i == `NAC_OFS_CONTROL)   || (paddr_i == `NAC_OFS_UNLOCK) ||
                       (paddr_i == `NAC_OFS_FLAG2);

   // zero wait states; only unmapped addresses are answered with an error
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped;

   ////////////////////////////////////////////////////////////////////////////
   // concatenated program word and address, upper unused bits dropped
   assign prog_addr = {st.addr_high[4:0], st.addr_low};
   assign prog_word = {st.data_high, st.data_low};

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unimplemented bits and the unlock register return zero
   function automatic logic [31:0] read_reg(input nac_ctl_t s, input logic [11:0] a);
      logic [31:0] r;
      r = '0;
      unique case (a)
         `NAC_OFS_DATA_LOW:  r[7:0] = s.data_low;
         `NAC_OFS_DATA_HIGH: r[5:0] = s.data_high;
         `NAC_OFS_ADDR_LOW:  r[7:0] = s.addr_low;
         `NAC_OFS_ADDR_HIGH: r[7:0] = s.addr_high;
         `NAC_OFS_CONTROL:
         begin
            r[`NAC_CTL_SEL]   = s.sel;
            r[`NAC_CTL_ABORT] = s.abort;
            r[`NAC_CTL_WRITE_ENABLE_GATE]  = s.write_enable_gate;
            r[`NAC_CTL_WR]    = s.wr;
            r[`NAC_CTL_RD]    = s.rd;
         end
         `NAC_OFS_FLAG2:     r[`NAC_FLAG2_DONE] = s.done;
         default:            r = '0;
      endcase
      return r;
   endfunction : read_reg

   ////////////////////////////////////////////////////////////////////////////
   // next state: bus writes, unlock tracking, sequencer
   always_comb
   begin
      next_st   = st;
      tmr_start = 1'b0;
      tmr_load  = DATA_WR_CYCLES;
      ee_we     = 1'b0;
      fl_we     = 1'b0;

      // read data is taken in the setup cycle and held through access
      if (setup_rd)
      begin
         next_st.prdata = read_reg(st, paddr_i);
      end

      // plain data and address registers: software may write at any time
      if (acc_wr && paddr_i == `NAC_OFS_DATA_LOW)
      begin
         next_st.data_low = wbyte;
      end
      if (acc_wr && paddr_i == `NAC_OFS_DATA_HIGH)
      begin
         next_st.data_high = wbyte[5:0];
      end
      if (acc_wr && paddr_i == `NAC_OFS_ADDR_LOW)
      begin
         next_st.addr_low = wbyte;
      end
      if (acc_wr && paddr_i == `NAC_OFS_ADDR_HIGH)
      begin
         next_st.addr_high = wbyte;
      end

      // unlock stages: 55h arms, AAh after 55h completes; anything else breaks
      if (acc_wr && paddr_i == `NAC_OFS_UNLOCK)
      begin
         if (wbyte == `NAC_KEY_FIRST)
         begin
            next_st.unlock = 2'd1;
         end
         else if (wbyte == `NAC_KEY_SECOND && st.unlock == 2'd1)
         begin
            next_st.unlock = 2'd2;
         end
         else
         begin
            next_st.unlock = 2'd0;
         end
      end
      else if (acc_wr)
      begin
         next_st.unlock = 2'd0;
      end

      // control register: bits 6..4 have no storage
      if (acc_wr && paddr_i == `NAC_OFS_CONTROL)
      begin
         next_st.write_enable_gate = wbyte[`NAC_CTL_WRITE_ENABLE_GATE];
         if (st.fsm == NAC_IDLE)
         begin
            next_st.sel = wbyte[`NAC_CTL_SEL];
            // write start needs an earlier enable and a finished unlock
            if (wbyte[`NAC_CTL_WR] && st.write_enable_gate && st.unlock == 2'd2)
            begin
               next_st.wr  = 1'b1;
               next_st.fsm = NAC_WR_BUSY;
               tmr_start   = 1'b1;
            end
            else if (wbyte[`NAC_CTL_RD])
            begin
               next_st.rd  = 1'b1;
               next_st.fsm = wbyte[`NAC_CTL_SEL] ? NAC_RD_PROG1 : NAC_RD_DATA;
            end
         end
      end
      // a write of zero to rd or wr never clears them
      tmr_load = next_st.sel ? PROG_WR_CYCLES : DATA_WR_CYCLES;

      // software clears the done flag by writing zero
      if (acc_wr && paddr_i == `NAC_OFS_FLAG2 && !wbyte[`NAC_FLAG2_DONE])
      begin
         next_st.done = 1'b0;
      end

      // sequencer
      unique case (st.fsm)
         NAC_IDLE:
         begin
         end
         NAC_RD_DATA:
         begin
            next_st.data_low = ee_rdata;
            next_st.rd       = 1'b0;
            next_st.fsm      = NAC_IDLE;
         end
         NAC_RD_PROG1:
         begin
            next_st.fsm = NAC_RD_PROG2;
         end
         NAC_RD_PROG2:
         begin
            next_st.data_low  = fl_rdata[7:0];
            next_st.data_high = fl_rdata[13:8];
            next_st.rd        = 1'b0;
            next_st.fsm       = NAC_IDLE;
         end
         NAC_WR_BUSY:
         begin
            // completion: store, clear start and raise done in one cycle
            if (tmr_done)
            begin
               ee_we        = ~st.sel;
               fl_we        = st.sel;
               next_st.wr   = 1'b0;
               next_st.done = 1'b1;
               next_st.abort = 1'b0;
               next_st.fsm  = NAC_IDLE;
            end
         end
         default:
         begin
            next_st.fsm = NAC_IDLE;
         end
      endcase

      // external or watchdog reset: abort, keep data, address and select
      if (soft_reset)
      begin
         ee_we          = 1'b0;
         fl_we          = 1'b0;
         next_st.abort  = (st.fsm == NAC_WR_BUSY) ? 1'b1 : st.abort;
         next_st.wr     = 1'b0;
         next_st.rd     = 1'b0;
         next_st.write_enable_gate   = 1'b0;
         next_st.unlock = 2'd0;
         next_st.fsm    = NAC_IDLE;
         next_st.data_low  = st.data_low;
         next_st.data_high = st.data_high;
         next_st.addr_low  = st.addr_low;
         next_st.addr_high = st.addr_high;
         next_st.sel       = st.sel;
         tmr_start         = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; power-on reset clears the write enable gate
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st           <= '0;
         st.fsm       <= NAC_IDLE;
         st.data_low  <= `NAC_RST_BYTE;
         st.data_high <= `NAC_RST_DATA_HIGH;
         st.addr_low  <= `NAC_RST_BYTE;
         st.addr_high <= `NAC_RST_BYTE;
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU facing: program writes stall fetch and hold interrupts pending;
   // the peripherals share clk_sys_i and keep running
   assign cpu_stall_o = (st.fsm == NAC_WR_BUSY) & st.sel;
   assign irq_hold_o  = (st.fsm == NAC_WR_BUSY) & st.sel;
   assign prdata_o    = st.prdata;

   ////////////////////////////////////////////////////////////////////////////
   // write timer; a cancel on abort keeps a stale done from completing later
   nac_write_timer u_timer
   (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .start_i   (tmr_start),
      .cancel_i  (soft_reset),
      .load_i    (tmr_load),
      .done_o    (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // arrays: only six and eleven address bits reach them, upper bits ignored
   nac_mem_array
   #(
      .W     (8),
      .AW    (6),
      .DEPTH (64)
   )
   u_eeprom
   (
      .clk_sys_i (clk_sys_i),
      .we_i      (ee_we),
      .waddr_i   (st.addr_low[5:0]),
      .wdata_i   (st.data_low),
      .raddr_i   (st.addr_low[5:0]),
      .rdata_o   (ee_rdata)
   );

   nac_mem_array
   #(
      .W     (14),
      .AW    (11),
      .DEPTH (2048)
   )
   u_flash
   (
      .clk_sys_i (clk_sys_i),
      .we_i      (fl_we),
      .waddr_i   (prog_addr[10:0]),
      .wdata_i   (prog_word),
      .raddr_i   (prog_addr[10:0]),
      .rdata_o   (fl_rdata)
   );

endmodule : nac_ctrl

`default_nettype wire

// [core/nac_mem_array.sv]
// nac_mem_array: one nonvolatile array, single location written per strobe.
// assumes: write strobe and address come from the controller sequencer.
`timescale 1ns/100ps
`default_nettype none

module nac_mem_array
#(
   parameter int W     = 8,
   parameter int AW    = 6,
   parameter int DEPTH = 64
)
(
   input  wire logic          clk_sys_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [W-1:0]  wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [W-1:0]  rdata_o
);

   // contents survive reset, so no reset term on the array
   logic [W-1:0] cells [DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // a write replaces the old word whole: erase and program in one step
   always_ff @(posedge clk_sys_i)
   begin
      if (we_i)
      begin
         cells[waddr_i] <= wdata_i;
      end
   end

   // read is asynchronous; the controller registers it
   assign rdata_o = cells[raddr_i];

endmodule : nac_mem_array

`default_nettype wire

// [core/nac_pkg.sv]
// nac_pkg: types of the memory access controller.
// assumes: compiled before every module of the block.
package nac_pkg;

   // sequencer states, gray coded along idle -> read -> fetch -> write
   typedef enum logic [2:0] {
      NAC_IDLE     = 3'b000,
      NAC_RD_DATA  = 3'b001,
      NAC_RD_PROG1 = 3'b011,
      NAC_RD_PROG2 = 3'b010,
      NAC_WR_BUSY  = 3'b110
   } nac_fsm_t;

   // whole state of the controller top
   typedef struct packed {
      nac_fsm_t    fsm;
      logic [7:0]  data_low;
      logic [5:0]  data_high;
      logic [7:0]  addr_low;
      logic [7:0]  addr_high;
      logic        sel;
      logic        abort;
      logic        write_enable_gate;
      logic        wr;
      logic        rd;
      logic [1:0]  unlock;
      logic        done;
      logic [31:0] prdata;
   } nac_ctl_t;

   // state of the write timer
   typedef struct packed {
      logic [31:0] count;
      logic        run;
      logic        done;
   } nac_tmr_t;

endpackage : nac_pkg

// [core/nac_regs.svh]
// nac_regs.svh: register offsets, field positions, reset values and timing
// counts of the memory access controller.
// assumes: included by bare name; holds definitions only.
`ifndef NAC_REGS_SVH
`define NAC_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// byte offsets on the register bus, one aligned word each
`define NAC_OFS_DATA_LOW    12'h180
`define NAC_OFS_DATA_HIGH   12'h184
`define NAC_OFS_ADDR_LOW    12'h188
`define NAC_OFS_ADDR_HIGH   12'h1a0
`define NAC_OFS_CONTROL     12'h18c
`define NAC_OFS_UNLOCK      12'h190
`define NAC_OFS_FLAG2       12'h194

////////////////////////////////////////////////////////////////////////////////
// field positions of memory_access_control and peripheral_flag_reg2
`define NAC_CTL_RD          0
`define NAC_CTL_WR          1
`define NAC_CTL_WRITE_ENABLE_GATE        2
`define NAC_CTL_ABORT       3
`define NAC_CTL_SEL         7
`define NAC_FLAG2_DONE      4

////////////////////////////////////////////////////////////////////////////////
// reset values and unlock keys
`define NAC_RST_BYTE        8'h00
`define NAC_RST_DATA_HIGH   6'h00
`define NAC_KEY_FIRST       8'h55
`define NAC_KEY_SECOND      8'haa

////////////////////////////////////////////////////////////////////////////////
// timing: write times in microseconds, clock in MHz, counts derived
`define NAC_CLK_MHZ         100
`define NAC_DATA_WR_TIME_US 4000
`define NAC_PROG_WR_TIME_US 2000
`define NAC_DATA_WR_CYC     (`NAC_DATA_WR_TIME_US * `NAC_CLK_MHZ)
`define NAC_PROG_WR_CYC     (`NAC_PROG_WR_TIME_US * `NAC_CLK_MHZ)

`endif

// [core/nac_write_timer.sv]
// nac_write_timer: on-chip timer that sets the length of a write.
// assumes: start is a single-cycle pulse from the sequencer; cancel is one from the two reset inputs.
`timescale 1ns/100ps
`default_nettype none

module nac_write_timer
   import nac_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire logic        cancel_i,
   input  wire logic [31:0] load_i,
   output logic             done_o
);

   nac_tmr_t st;
   nac_tmr_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // count down; done pulses for one cycle load_i cycles after start
   always_comb
   begin
      next_st      = st;
      next_st.done = 1'b0;
      if (cancel_i)
      begin
         next_st.run = 1'b0;
      end
      else if (start_i)
      begin
         next_st.run   = 1'b1;
         next_st.count = load_i;
      end
      else if (st.run)
      begin
         if (st.count <= 32'h0000_0001)
         begin
            next_st.run  = 1'b0;
            next_st.done = 1'b1;
         end
         else
         begin
            next_st.count = st.count - 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign done_o = st.done;

endmodule : nac_write_timer

`default_nettype wire

// [verif/nac_cpu_model.sv]
// nac_cpu_model: the CPU beside the controller; counts stalled cycles and
// keeps an interrupt event pending while interrupts are held.
// assumes: events are one-cycle pulses on clk_sys_i.
`timescale 1ns/100ps
`default_nettype none

module nac_cpu_model
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        cpu_stall_i,
   input  wire logic        irq_hold_i,
   input  wire logic        irq_event_i,
   output logic      [15:0] stall_cycles_o,
   output logic             irq_pending_o,
   output logic      [3:0]  irq_taken_o
);
   // no fetch while stalled; an event waits until the hold drops
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stall_cycles_o <= 16'h0;
         irq_pending_o  <= 1'b0;
         irq_taken_o    <= 4'h0;
      end
      else
      begin
         if (cpu_stall_i)
            stall_cycles_o <= stall_cycles_o + 16'h1;
         if (irq_event_i || irq_pending_o)
         begin
            irq_pending_o <= irq_hold_i;
            irq_taken_o   <= irq_taken_o + {3'h0, !irq_hold_i};
         end
      end
   end
endmodule : nac_cpu_model
`default_nettype wire

// [verif/nac_ctrl_checker.sv]
// nac_ctrl_checker: bus answer and stall properties of the access controller.
// assumes: bound to nac_ctrl; one clock domain, reset active low.
`timescale 1ns/100ps
`default_nettype none
`include "nac_regs.svh"

module nac_ctrl_checker
#(
   parameter int PROG_WR_CYCLES = 3
)
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        external_reset_pin_i,
   input  wire logic        watchdog_timeout_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] prdata_o,
   input  wire logic        pready_o,
   input  wire logic        pslverr_o,
   input  wire logic        cpu_stall_o,
   input  wire logic        irq_hold_o
);
   localparam int STALL_MAX = PROG_WR_CYCLES + 2;
   logic mapped;

   // addr_high sits apart from control, so it has its own offset
   assign mapped = paddr_i inside {`NAC_OFS_DATA_LOW, `NAC_OFS_DATA_HIGH, `NAC_OFS_ADDR_LOW,
                                   `NAC_OFS_CONTROL, `NAC_OFS_UNLOCK, `NAC_OFS_FLAG2,
                                   `NAC_OFS_ADDR_HIGH};

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   ////////////////////////////////////////////////////////////////////////////////
   // a read setup loads prdata_o at its edge, so the access cycle shows it
   sequence rd_setup(logic [11:0] a);
      psel_i && !penable_i && !pwrite_i && paddr_i == a;
   endsequence
   sequence access;
      psel_i && penable_i;
   endsequence

   chk_ready_access: assert property (access |-> pready_o)
      else $error("pready low in access");
   chk_err_unmapped: assert property (access ##0 !mapped |-> pslverr_o)
      else $error("no error on unmapped access");
   chk_err_mapped: assert property (access ##0 mapped |-> !pslverr_o)
      else $error("error on mapped access");
   chk_unlock_zero: assert property (rd_setup(`NAC_OFS_UNLOCK) |=> prdata_o == 32'h0)
      else $error("unlock reads nonzero");
   chk_ctl_unused: assert property (rd_setup(`NAC_OFS_CONTROL) |=>
      prdata_o[31:8] == 24'h0 && prdata_o[6:4] == 3'h0)
      else $error("control unused bits nonzero");
   chk_high_upper: assert property (rd_setup(`NAC_OFS_DATA_HIGH) |=> prdata_o[31:6] == 26'h0)
      else $error("data high upper bits nonzero");
   chk_low_upper: assert property (rd_setup(`NAC_OFS_DATA_LOW) |=> prdata_o[31:8] == 24'h0)
      else $error("data low upper bits nonzero");
   chk_hold_stall: assert property (irq_hold_o == cpu_stall_o)
      else $error("interrupt hold differs from stall");
   chk_stall_ends: assert property ($rose(cpu_stall_o) |-> ##[1:STALL_MAX] !cpu_stall_o)
      else $error("stall too long");
   chk_abort_release: assert property ((external_reset_pin_i || watchdog_timeout_i) |=>
      !cpu_stall_o)
      else $error("stall survives reset event");
endmodule : nac_ctrl_checker
`default_nettype wire

// [verif/nvm_access_controller_tb.sv]
// nvm_access_controller_tb: register-level tests of nac_ctrl over APB.
// assumes: short write times (5 and 3 cycles) set by parameter.
`timescale 1ns/100ps
`default_nettype none
`include "nac_regs.svh"

module nvm_access_controller_tb;
   import nac_pkg::*;
   localparam logic [11:0] CTL = `NAC_OFS_CONTROL;
   localparam logic [11:0] ULK = `NAC_OFS_UNLOCK;
   localparam logic [11:0] DLO = `NAC_OFS_DATA_LOW;
   localparam logic [11:0] DHI = `NAC_OFS_DATA_HIGH;
   localparam logic [11:0] ALO = `NAC_OFS_ADDR_LOW;
   localparam logic [11:0] AHI = `NAC_OFS_ADDR_HIGH;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, ext_rst = 1'b0, wdt = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, irq_event_i = 1'b0;
   logic [11:0] paddr_i = 12'h0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
   logic        pready_o, pslverr_o, cpu_stall_o, irq_hold_o, rerr, irq_pending_o;
   logic [15:0] stall_cycles_o;
   logic [3:0]  irq_taken_o;
   int          miscompares = 0, check_count = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   nac_ctrl #(.DATA_WR_CYCLES(5), .PROG_WR_CYCLES(3)) i_nac_ctrl (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .external_reset_pin_i(ext_rst), .watchdog_timeout_i(wdt),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .cpu_stall_o(cpu_stall_o), .irq_hold_o(irq_hold_o));
   nac_cpu_model i_nac_cpu_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .cpu_stall_i(cpu_stall_o), .irq_hold_i(irq_hold_o), .irq_event_i(irq_event_i),
      .stall_cycles_o(stall_cycles_o), .irq_pending_o(irq_pending_o),
      .irq_taken_o(irq_taken_o));

   ////////////////////////////////////////////////////////////////////////////////
   // one APB transfer; the answer is waited for, never assumed
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, a, 24'h0, d};
      irq_event_i <= 1'b0;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
      end
      while (pready_o !== 1'b1);
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask : check_bit

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check_val(rdat, {24'h0, exp});
   endtask : rd_chk

   // the unlock keys must come back to back right before the start
   task automatic start_wr(input logic [7:0] ctl);
      apb(1'b1, ULK, `NAC_KEY_FIRST);
      apb(1'b1, ULK, `NAC_KEY_SECOND);
      apb(1'b1, CTL, ctl);
   endtask : start_wr

   task automatic wait_wr;
      int n;
      n = 0;
      do
      begin
         apb(1'b0, CTL, 8'h00);
         n++;
      end
      while (rdat[1] !== 1'b0 && n < 20);
      if (n >= 20)
         miscompares++;
   endtask : wait_wr

   task automatic wrap_up;
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under 2000 cycles
   initial
   begin
      #100000;
      miscompares++;
      wrap_up();
   end

   initial
   begin
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd_chk(CTL, 8'h00);
      rd_chk(ULK, 8'h00);
      apb(1'b1, CTL, 8'h74);
      rd_chk(CTL, 8'h04);
      apb(1'b0, 12'h1fc, 8'h00);
      check_bit(rerr, 1'b1);
      // refused starts: no keys, broken keys, enable in the same write
      apb(1'b1, ALO, 8'h05);
      apb(1'b1, DLO, 8'h3c);
      apb(1'b1, CTL, 8'h06);
      rd_chk(CTL, 8'h04);
      apb(1'b1, ULK, `NAC_KEY_FIRST);
      apb(1'b1, DLO, 8'h3c);
      apb(1'b1, ULK, `NAC_KEY_SECOND);
      apb(1'b1, CTL, 8'h06);
      rd_chk(CTL, 8'h04);
      apb(1'b1, CTL, 8'h00);
      start_wr(8'h06);
      rd_chk(CTL, 8'h04);
      // data write; software cannot clear the start bit meanwhile
      start_wr(8'h06);
      apb(1'b1, CTL, 8'h04);
      rd_chk(CTL, 8'h06);
      wait_wr();
      rd_chk(`NAC_OFS_FLAG2, 8'h10);
      apb(1'b1, `NAC_OFS_FLAG2, 8'h00);
      rd_chk(`NAC_OFS_FLAG2, 8'h00);
      rd_chk(CTL, 8'h04);
      apb(1'b1, DLO, 8'h00);
      apb(1'b1, CTL, 8'h05);
      rd_chk(DLO, 8'h3c);
      // program write at the top word, select change refused while busy
      apb(1'b1, AHI, 8'h07);
      apb(1'b1, ALO, 8'hff);
      apb(1'b1, DHI, 8'h3f);
      apb(1'b1, DLO, 8'ha5);
      apb(1'b1, CTL, 8'h84);
      start_wr(8'h86);
      irq_event_i <= 1'b1;
      apb(1'b1, CTL, 8'h04);
      check_bit(irq_pending_o, 1'b1);
      check_bit(irq_taken_o == 4'h0, 1'b1);
      wait_wr();
      check_bit(irq_taken_o == 4'h1, 1'b1);
      check_bit(stall_cycles_o >= 16'd3, 1'b1);
      rd_chk(CTL, 8'h84);
      apb(1'b1, DLO, 8'h00);
      apb(1'b1, DHI, 8'h00);
      apb(1'b1, CTL, 8'h85);
      @(posedge clk_sys_i);
      rd_chk(DLO, 8'ha5);
      rd_chk(DHI, 8'h3f);
      // each reset source cuts a data write; registers survive for a retry
      for (int s = 0; s < 2; s++)
      begin
         apb(1'b1, ALO, 8'h05);
         apb(1'b1, DLO, 8'h99);
         apb(1'b1, CTL, 8'h04);
         start_wr(8'h06);
         @(posedge clk_sys_i);
         {ext_rst, wdt} <= (s == 0) ? 2'b10 : 2'b01;
         @(posedge clk_sys_i);
         {ext_rst, wdt} <= 2'b00;
         rd_chk(CTL, 8'h08);
         rd_chk(DLO, 8'h99);
         rd_chk(ALO, 8'h05);
         apb(1'b1, CTL, 8'h01);
         rd_chk(DLO, 8'h3c);
      end
      wrap_up();
   end
endmodule : nvm_access_controller_tb

bind nac_ctrl nac_ctrl_checker #(.PROG_WR_CYCLES(PROG_WR_CYCLES)) i_nac_ctrl_checker (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .external_reset_pin_i(external_reset_pin_i),
   .watchdog_timeout_i(watchdog_timeout_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .cpu_stall_o(cpu_stall_o), .irq_hold_o(irq_hold_o));
`default_nettype wire
